// ==== core/mem_refresh_pkg.sv ====
// constants and types shared by the refresh timer and memory option block
// assumes a single 50 MHz system clock and an Avalon-MM register port
package mem_refresh_pkg;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [4:0] OFS_MTC  = 5'h00; // memory_timing_control
    localparam logic [4:0] OFS_RTCS = 5'h04; // refresh_timer_ctrl_status
    localparam logic [4:0] OFS_RCNT = 5'h08; // refresh_interval_counter
    localparam logic [4:0] OFS_RCON = 5'h0C; // refresh_compare_constant
    localparam logic [4:0] OFS_BC1  = 5'h10; // bus_control_one
    localparam logic [4:0] OFS_BSZ  = 5'h14; // area_bus_size_control

    // ****************************************************************
    // reset values and writable masks
    // ****************************************************************
    localparam logic [15:0] RST_MTC   = 16'h0000;
    localparam logic [15:0] RST_RTCS  = 16'h0000;
    localparam logic [7:0]  RST_RCNT  = 8'h00;
    localparam logic [7:0]  RST_RCON  = 8'h00;
    localparam logic [15:0] RST_BC1   = 16'h0000;
    localparam logic [15:0] RST_BSZ   = 16'h00FC;
    localparam logic [15:0] MASK_MTC  = 16'hFEFC;
    localparam logic [15:0] MASK_BC1  = 16'h1007;
    localparam logic [15:0] MASK_BSZ  = 16'h00FC;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int POS_BURST    = 10; // page_burst_enable
    localparam int POS_BANKHOLD = 9;  // bank_hold_mode
    localparam int POS_AMX2     = 7;  // addr_mux_select top bit
    localparam int POS_WIDTH    = 6;  // mem_width_select
    localparam int POS_AMX0     = 4;  // addr_mux_select low two bits
    localparam int POS_REFON    = 3;  // refresh_on
    localparam int POS_SELF     = 2;  // self_refresh_select
    localparam int POS_FLAG     = 7;  // compare_match_flag
    localparam int POS_IRQEN    = 6;  // match_irq_enable
    localparam int POS_CKS      = 3;  // counter_clock_select low bit
    localparam int POS_ENDIAN   = 12; // little endian select for area 2
    localparam int POS_AMT      = 0;  // area_memory_type low bit
    localparam int POS_SZ1      = 2;  // area 1 size field low bit

    // ****************************************************************
    // prescaler: divide ratio as a power of two, per clock select code
    // ****************************************************************
    localparam int PRE_BITS = 12;
    localparam logic [3:0] DIV_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6,
                                             4'h8, 4'hA, 4'hB, 4'hC};

    // ****************************************************************
    // encodings
    // ****************************************************************
    typedef enum logic [1:0] {KIND_PLAIN, KIND_SDRAM, KIND_DRAM, KIND_PSRAM} area_kind_type;
    localparam logic [1:0] WID_BYTE = 2'h1; // bus size codes
    localparam logic [1:0] WID_WORD = 2'h2;
    localparam logic [1:0] WID_LONG = 2'h3;

endpackage

// ==== core/refresh_prescaler.sv ====
// free running divider that issues one-cycle ticks for the refresh counter
// assumes select comes from a register on the same clock
`timescale 1ns/1ps
module refresh_prescaler
    import mem_refresh_pkg::*;
#(
    parameter int BITS = PRE_BITS
) (
    input  wire logic       REF_CLK,
    input  wire logic       ARST_N,
    input  wire logic [2:0] SEL,
    output logic            TICK
);

    typedef struct packed {
        logic [BITS-1:0] count;
        logic            tick;
    } pre_state_type;

    pre_state_type state;
    pre_state_type next_state;
    logic [BITS-1:0] mask;

    // ****************************************************************
    // tick when the low bits selected by a nonzero code are all ones; code 0 never ticks
    // ****************************************************************
    always_comb begin
        mask = BITS'((1 << DIV_SHIFT[SEL]) - 1);
        next_state = state;
        next_state.count = state.count + 1'b1;
        next_state.tick = (SEL != 3'h0) && ((state.count & mask) == mask);
    end

    // state register
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign TICK = state.tick;

endmodule

// ==== core/memory_refresh_and_alignment.sv ====
// memory type options, refresh interval timer and access alignment planner
// assumes an Avalon-MM master on REF_CLK and a bus sequencer that runs the
// planned device cycles and pulses REFRESH_DONE after each refresh
`timescale 1ns/1ps
module memory_refresh_and_alignment
    import mem_refresh_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        ARST_N,
    input  wire logic [4:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        SLAVE_MODE,
    input  wire logic [1:0]  AREA0_WIDTH,
    input  wire logic        ACC_VALID,
    input  wire logic [1:0]  ACC_AREA,
    input  wire logic [1:0]  ACC_SIZE,
    input  wire logic        ACC_FETCH,
    input  wire logic [31:0] ACC_ADDR,
    input  wire logic        ACC_BUSY,
    input  wire logic        REFRESH_DONE,
    output logic             XFER_VALID,
    output logic [31:0]      XFER_ADDR,
    output logic [1:0]       XFER_WIDTH,
    output logic [2:0]       XFER_COUNT,
    output logic             XFER_BURST,
    output logic             XFER_AUTO_PRE,
    output logic             XFER_SWAP,
    output logic [1:0]       XFER_KIND,
    output logic [3:0]       COL_BITS,
    output logic [2:0]       SDRAM_ORG,
    output logic             CFG_ERROR,
    output logic             REFRESH_REQ,
    output logic             SELF_REFRESH,
    output logic             IRQ
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [15:0] mtc;
        logic [15:0] rtcs;
        logic [7:0]  count;
        logic [7:0]  constant;
        logic [15:0] bc1;
        logic [15:0] bsz;
        logic        armed;
        logic        pending;
        logic        self_active;
        logic        ack;
        logic [31:0] rdata;
        logic [1:0]  slave_meta;
        logic [3:0]  width_meta;
        logic        xvalid;
        logic [31:0] xaddr;
        logic [1:0]  xwidth;
        logic [2:0]  xcount;
        logic        xburst;
        logic        xpre;
        logic        xswap;
        logic [1:0]  xkind;
    } core_state_type;

    core_state_type state;
    core_state_type next_state;
    logic           tick;
    logic           req;
    logic           wr_en;
    logic           slave;
    logic           refresh_on;
    logic           special_busy;
    logic [7:0]     inc;
    logic           match;
    logic [15:0]    wdata;
    logic [15:0]    lane;
    logic [2:0]     amt;
    logic [2:0]     amx;
    logic           width_long;
    area_kind_type  kind;
    logic [1:0]     width;
    logic [1:0]     size;
    logic [3:0]     dev_bytes;
    logic [3:0]     acc_bytes;

    // ****************************************************************
    // prescaler
    // ****************************************************************
    refresh_prescaler u_pre (
        .REF_CLK (REF_CLK),
        .ARST_N  (ARST_N),
        .SEL     (state.rtcs[POS_CKS +: 3]),
        .TICK    (tick)
    );

    // ****************************************************************
    // decoded controls
    // ****************************************************************
    assign req = AVS_READ || AVS_WRITE;
    assign wr_en = AVS_WRITE && state.ack;
    assign slave = state.slave_meta[1];
    assign refresh_on = state.mtc[POS_REFON] && !slave;
    assign amt = state.bc1[POS_AMT +: 3];
    assign amx = {state.mtc[POS_AMX2], state.mtc[POS_AMX0 +: 2]};
    assign width_long = state.mtc[POS_WIDTH];
    assign lane = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    assign wdata = AVS_WRITEDATA[15:0];
    assign inc = state.count + 8'h01;
    assign match = tick && (inc == state.constant);

    // area kind from the memory type field
    always_comb begin
        kind = KIND_PLAIN;
        unique case (ACC_AREA)
            2'h2: begin
                if (amt == 3'h4 || amt == 3'h5) kind = KIND_SDRAM;
            end
            2'h3: begin
                if (amt == 3'h1 || amt == 3'h5) kind = KIND_SDRAM;
                else if (amt == 3'h2) kind = KIND_DRAM;
                else if (amt == 3'h3) kind = KIND_PSRAM;
            end
            2'h0, 2'h1: kind = KIND_PLAIN;
        endcase
    end

    // device width of the addressed area
    always_comb begin
        if (kind != KIND_PLAIN) begin
            width = width_long ? WID_LONG : WID_WORD;
        end else if (ACC_AREA == 2'h0) begin
            width = state.width_meta[3:2];
        end else begin
            width = state.bsz[POS_SZ1 + 2 * (32'(ACC_AREA) - 1) +: 2];
        end
        size = ACC_FETCH ? WID_LONG : ACC_SIZE;
        dev_bytes = 4'h1 << (width - 2'h1);
        acc_bytes = 4'h1 << (size - 2'h1);
    end

    // an SDRAM or PSRAM cycle in progress holds off self refresh entry
    assign special_busy = ACC_BUSY && (state.xkind == KIND_SDRAM || state.xkind == KIND_PSRAM);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_state = state;
        // pin synchronisers
        next_state.slave_meta = {state.slave_meta[0], SLAVE_MODE};
        next_state.width_meta = {state.width_meta[1:0], AREA0_WIDTH};
        // bus answer one cycle after the request appears
        next_state.ack = req && !state.ack;
        if (AVS_READ && !state.ack) begin
            next_state.rdata = 32'h0000_0000; // unmapped reads zero
            unique case (AVS_ADDRESS)
                OFS_MTC:  next_state.rdata[15:0] = state.mtc;
                OFS_RTCS: next_state.rdata[15:0] = {8'h00, state.rtcs[7:0]};
                OFS_RCNT: next_state.rdata[15:0] = {8'h00, state.count};
                OFS_RCON: next_state.rdata[15:0] = {8'h00, state.constant};
                OFS_BC1:  next_state.rdata[15:0] = state.bc1;
                OFS_BSZ:  next_state.rdata[15:0] = state.bsz;
                default:  next_state.rdata = 32'h0000_0000;
            endcase
            if (AVS_ADDRESS == OFS_RTCS && state.rtcs[POS_FLAG]) begin
                next_state.armed = 1'b1;
            end
        end
        // register writes take effect at the answering edge
        if (wr_en) begin
            unique case (AVS_ADDRESS)
                OFS_MTC: begin
                    next_state.mtc = (state.mtc & ~(lane & MASK_MTC)) | (wdata & lane & MASK_MTC);
                end
                OFS_RTCS: begin
                    if (AVS_BYTEENABLE[0]) begin
                        next_state.rtcs[POS_IRQEN] = wdata[POS_IRQEN];
                        next_state.rtcs[POS_CKS +: 3] = wdata[POS_CKS +: 3];
                        if (!wdata[POS_FLAG] && state.armed) begin
                            next_state.rtcs[POS_FLAG] = 1'b0;
                            next_state.armed = 1'b0;
                        end
                    end
                end
                OFS_BC1: begin
                    next_state.bc1 = (state.bc1 & ~(lane & MASK_BC1)) | (wdata & lane & MASK_BC1);
                end
                OFS_BSZ: begin
                    next_state.bsz = (state.bsz & ~(lane & MASK_BSZ)) | (wdata & lane & MASK_BSZ);
                end
                default: begin
                end
            endcase
        end
        // interval counter: CPU write wins over counting
        if (wr_en && AVS_ADDRESS == OFS_RCNT && AVS_BYTEENABLE[0]) begin
            next_state.count = wdata[7:0];
        end else if (match) begin
            next_state.count = 8'h00;
        end else if (tick) begin
            next_state.count = inc;
        end
        if (wr_en && AVS_ADDRESS == OFS_RCON && AVS_BYTEENABLE[0]) begin
            next_state.constant = wdata[7:0];
        end
        // a match sets the flag even in the cycle software clears it
        if (match) begin
            next_state.rtcs[POS_FLAG] = 1'b1;
        end
        // self refresh entry and exit
        if (!refresh_on || !state.mtc[POS_SELF]) begin
            next_state.self_active = 1'b0;
        end else if (!special_busy) begin
            next_state.self_active = 1'b1;
        end
        // refresh request: done clears, a new match sets; never counted
        if (REFRESH_DONE) begin
            next_state.pending = 1'b0;
        end
        if (match && refresh_on && !state.self_active) begin
            next_state.pending = 1'b1;
        end
        if (!refresh_on || state.self_active) begin
            next_state.pending = 1'b0;
        end
        // access plan captured per request
        next_state.xvalid = ACC_VALID;
        if (ACC_VALID) begin
            next_state.xkind = kind;
            next_state.xwidth = width;
            next_state.xaddr = ACC_FETCH ? {ACC_ADDR[31:2], 2'b00} : ACC_ADDR;
            next_state.xcount = (acc_bytes > dev_bytes) ? 3'(acc_bytes / dev_bytes) : 3'h1;
            next_state.xburst = (kind == KIND_SDRAM) ||
                ((kind == KIND_DRAM || kind == KIND_PSRAM) && state.mtc[POS_BURST]);
            next_state.xpre = (kind == KIND_SDRAM) &&
                (!state.mtc[POS_BANKHOLD] || ACC_AREA == 2'h2);
            next_state.xswap = state.bc1[POS_ENDIAN] && ACC_AREA == 2'h2 && width != WID_BYTE;
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= '0;
            state.mtc <= RST_MTC;
            state.rtcs <= RST_RTCS;
            state.count <= RST_RCNT;
            state.constant <= RST_RCON;
            state.bc1 <= RST_BC1;
            state.bsz <= RST_BSZ;
            state.xwidth <= WID_LONG;
            state.xcount <= 3'h1;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign AVS_WAITREQUEST = req && !state.ack;
    assign AVS_READDATA = state.rdata;
    assign XFER_VALID = state.xvalid;
    assign XFER_ADDR = state.xaddr;
    assign XFER_WIDTH = state.xwidth;
    assign XFER_COUNT = state.xcount;
    assign XFER_BURST = state.xburst;
    assign XFER_AUTO_PRE = state.xpre;
    assign XFER_SWAP = state.xswap;
    assign XFER_KIND = state.xkind;
    assign COL_BITS = 4'h8 + {2'b00, amx[1:0]};
    assign SDRAM_ORG = amx;
    // reserved or narrow-bus-illegal multiplex codes
    assign CFG_ERROR = (amx[2] && amx != 3'h7) ||
        (!width_long && (amx == 3'h1 || amx == 3'h2));
    // refresh waits while an external cycle runs
    assign REFRESH_REQ = state.pending && !ACC_BUSY;
    assign SELF_REFRESH = state.self_active;
    assign IRQ = state.rtcs[POS_FLAG] && state.rtcs[POS_IRQEN];

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    sdram_burst_a: assert property (XFER_VALID && XFER_KIND == KIND_SDRAM |-> XFER_BURST)
        else $error("sdram access planned without burst");
    area2_precharge_a: assert property (ACC_VALID && ACC_AREA == 2'h2 && kind == KIND_SDRAM
        |=> XFER_AUTO_PRE)
        else $error("area 2 sdram without auto precharge");
    special_width_a: assert property (ACC_VALID && kind != KIND_PLAIN
        |=> XFER_WIDTH == ($past(width_long) ? WID_LONG : WID_WORD))
        else $error("special memory width not from width bit");
    slave_refresh_a: assert property (slave |=> !REFRESH_REQ)
        else $error("refresh requested in slave mode");
    self_discard_a: assert property (state.self_active && !state.pending |=> !state.pending)
        else $error("refresh request raised during self refresh");
    flag_hold_a: assert property (state.rtcs[POS_FLAG] && !(wr_en && AVS_ADDRESS == OFS_RTCS)
        |=> state.rtcs[POS_FLAG])
        else $error("match flag lost without clearing write");
    irq_follow_a: assert property (match && state.rtcs[POS_IRQEN] |=> IRQ [*2]
        or (IRQ ##1 !state.rtcs[POS_FLAG]))
        else $error("interrupt not raised on enabled match");
    counter_clear_a: assert property (match && !(wr_en && AVS_ADDRESS == OFS_RCNT)
        |=> state.count == 8'h00 && state.rtcs[POS_FLAG])
        else $error("counter not cleared on match");
    byte_swap_a: assert property (XFER_VALID && XFER_WIDTH == WID_BYTE |-> !XFER_SWAP)
        else $error("lane swap on byte device");
    fetch_align_a: assert property (ACC_VALID && ACC_FETCH
        |=> XFER_ADDR[1:0] == 2'b00 && XFER_COUNT == 3'(4'h4 / $past(dev_bytes)))
        else $error("fetch not longword aligned");

endmodule

// ==== dv/refresh_sequencer_model.sv ====
// behavioural bus sequencer that services held refresh requests
// assumes the request is a level on the system clock
`timescale 1ns/1ps
module refresh_sequencer_model (
    input  wire logic REF_CLK,
    input  wire logic ARST_N,
    input  wire logic SLOW,
    input  wire logic REFRESH_REQ,
    output logic      REFRESH_DONE
);
    int wait_cnt;
    // one refresh per request, at once or after a slow delay
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wait_cnt     <= 0;
            REFRESH_DONE <= 1'b0;
        end else begin
            REFRESH_DONE <= 1'b0;
            if (REFRESH_REQ && !REFRESH_DONE) begin
                if (wait_cnt >= (SLOW ? 5 : 0)) begin
                    REFRESH_DONE <= 1'b1; // done pulse ends the held request
                    wait_cnt     <= 0;
                end else begin
                    wait_cnt <= wait_cnt + 1;
                end
            end
        end
    end
endmodule

// ==== dv/tb_memory_refresh_and_alignment.sv ====
// self-checking bench: register bus, refresh timer and access planner
// assumes mem_refresh_pkg is compiled first
`timescale 1ns/1ps
module tb_memory_refresh_and_alignment;
    import mem_refresh_pkg::*;
    logic        REF_CLK, ARST_N, AVS_READ, AVS_WRITE, SLAVE_MODE, ACC_VALID, ACC_FETCH;
    logic        ACC_BUSY, REFRESH_DONE, AVS_WAITREQUEST, XFER_VALID, XFER_BURST, f;
    logic        XFER_AUTO_PRE, XFER_SWAP, CFG_ERROR, REFRESH_REQ, SELF_REFRESH, IRQ, slow;
    logic [4:0]  AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, ACC_ADDR, XFER_ADDR, ad;
    logic [3:0]  AVS_BYTEENABLE, COL_BITS;
    logic [1:0]  AREA0_WIDTH, ACC_AREA, ACC_SIZE, XFER_WIDTH, XFER_KIND, ar, sz, dw;
    logic [2:0]  XFER_COUNT, SDRAM_ORG;
    logic [37:0] exp_rd[$];
    logic [37:0] exp_xf[$];
    int          err_total, n_checks, n, m;

    memory_refresh_and_alignment memory_refresh_and_alignment_inst (.REF_CLK, .ARST_N,
        .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
        .AVS_WAITREQUEST, .SLAVE_MODE, .AREA0_WIDTH, .ACC_VALID, .ACC_AREA, .ACC_SIZE,
        .ACC_FETCH, .ACC_ADDR, .ACC_BUSY, .REFRESH_DONE, .XFER_VALID, .XFER_ADDR,
        .XFER_WIDTH, .XFER_COUNT, .XFER_BURST, .XFER_AUTO_PRE, .XFER_SWAP, .XFER_KIND,
        .COL_BITS, .SDRAM_ORG, .CFG_ERROR, .REFRESH_REQ, .SELF_REFRESH, .IRQ);
    refresh_sequencer_model refresh_sequencer_model_inst (.REF_CLK, .ARST_N, .SLOW(slow),
        .REFRESH_REQ, .REFRESH_DONE);

    task automatic check(input logic [37:0] seen, input logic [37:0] want);
        n_checks++;
        if (seen !== want) begin
            err_total++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic hung(input logic bad);
        if (bad) begin
            err_total++;
            stop_test();
        end
    endtask
    // one Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d,
                       input logic [15:0] e);
        int k;
        k = 0;
        @(posedge REF_CLK);
        AVS_ADDRESS   <= a;
        AVS_WRITE     <= wr;
        AVS_READ      <= !wr;
        AVS_WRITEDATA <= {16'h0000, d};
        if (!wr) exp_rd.push_back({22'h000000, e});
        do begin
            @(posedge REF_CLK);
            k++;
        end while (AVS_WAITREQUEST !== 1'b0 && k < 50);
        hung(AVS_WAITREQUEST !== 1'b0);
        AVS_WRITE <= 1'b0;
        AVS_READ  <= 1'b0;
    endtask
    // plan one access and note the expected device cycles
    task automatic access(input logic [1:0] a, input logic [1:0] s, input logic ft,
                          input logic [31:0] adr, input logic [1:0] w, input logic sw);
        logic [2:0] b;
        logic [2:0] db;
        b  = (ft || s == 2'h3) ? 3'h4 : ((s == 2'h2) ? 3'h2 : 3'h1);
        db = 3'h1 << (w - 2'h1);
        @(posedge REF_CLK);
        ACC_VALID <= 1'b1;
        ACC_AREA  <= a;
        ACC_SIZE  <= s;
        ACC_FETCH <= ft;
        ACC_ADDR  <= adr;
        exp_xf.push_back({(b > db) ? 3'(b / db) : 3'h1, w, sw, ft ? {adr[31:2], 2'h0} : adr});
        @(posedge REF_CLK);
        ACC_VALID <= 1'b0;
    endtask
    task automatic wait_req(output int k);
        k = 0;
        do begin
            @(posedge REF_CLK);
            k++;
        end while (REFRESH_REQ !== 1'b1 && k < 20000);
        hung(REFRESH_REQ !== 1'b1);
    endtask
    // count edges until a held refresh request is released
    task automatic hold_req(output int k);
        k = 0;
        do begin
            @(posedge REF_CLK);
            k++;
        end while (REFRESH_REQ === 1'b1 && k < 20000);
        hung(REFRESH_REQ !== 1'b0);
    endtask

    // compare each read and each planned transfer with the oldest note
    always @(posedge REF_CLK) begin
        if (AVS_READ && AVS_WAITREQUEST === 1'b0 && exp_rd.size() > 0)
            check(AVS_READDATA, exp_rd.pop_front());
        if (XFER_VALID === 1'b1)
            check({XFER_COUNT, XFER_WIDTH, XFER_SWAP, XFER_ADDR}, exp_xf.pop_front());
    end
    // system clock, 20 ns period
    initial begin
        REF_CLK = 1'b0;
        forever #10 REF_CLK = ~REF_CLK;
    end
    // main sequence
    initial begin
        {ARST_N, AVS_READ, AVS_WRITE, SLAVE_MODE, ACC_VALID, ACC_FETCH, ACC_BUSY, slow} = '0;
        {AVS_ADDRESS, AVS_WRITEDATA, ACC_AREA, ACC_SIZE, ACC_ADDR} = '0;
        AVS_BYTEENABLE = 4'hF;
        AREA0_WIDTH = 2'h2;
        err_total = 0;
        n_checks = 0;
        void'($urandom(54));
        repeat (16) @(posedge REF_CLK);
        ARST_N <= 1'b1;
        bus(0, OFS_RTCS, 16'h0000, RST_RTCS);
        bus(1, OFS_RCON, 16'hFFFF, 16'h0000);
        bus(0, OFS_RCON, 16'h0000, 16'h00FF);
        bus(1, OFS_MTC, 16'hFFF3, 16'h0000);
        bus(0, OFS_MTC, 16'h0000, 16'hFEF0);
        check(COL_BITS, 4'hB);
        check(SDRAM_ORG, 3'h7);
        bus(1, 5'h18, 16'hFFFF, 16'h0000);
        bus(0, 5'h18, 16'h0000, 16'h0000);
        $display("registers done");
        bus(1, OFS_BSZ, 16'h00E4, 16'h0000);
        bus(1, OFS_BC1, 16'h1000, 16'h0000);
        for (int i = 0; i < 40; i++) begin
            ar = 2'($urandom % 4);
            sz = 2'(1 + $urandom % 3);
            f  = ($urandom % 4) == 0;
            ad = $urandom & ~((32'h1 << (sz - 2'h1)) - 32'h1);
            dw = (ar == 2'h0) ? 2'h2 : ar;
            access(ar, sz, f, ad, dw, ar == 2'h2);
        end
        bus(1, OFS_BC1, 16'h1004, 16'h0000);
        access(2'h2, 2'h3, 1'b0, 32'h0000_0100, 2'h3, 1'b1);
        repeat (2) @(posedge REF_CLK);
        check(XFER_BURST, 1'b1);
        check(XFER_AUTO_PRE, 1'b1);
        check(XFER_KIND, KIND_SDRAM);
        bus(1, OFS_BC1, 16'h1005, 16'h0000);
        access(2'h3, 2'h3, 1'b0, 32'h0000_0200, 2'h3, 1'b0);
        repeat (2) @(posedge REF_CLK);
        check(XFER_AUTO_PRE, 1'b0);
        $display("planner done");
        ACC_BUSY <= 1'b1;
        bus(1, OFS_MTC, 16'h0018, 16'h0000);
        bus(1, OFS_RCON, 16'h0003, 16'h0000);
        bus(1, OFS_RTCS, 16'h0048, 16'h0000);
        repeat (40) @(posedge REF_CLK);
        check(CFG_ERROR, 1'b1);
        check(COL_BITS, 4'h9);
        check(REFRESH_REQ, 1'b0);
        check(IRQ, 1'b1);
        bus(1, OFS_RTCS, 16'h0040, 16'h0000);
        bus(0, OFS_RTCS, 16'h0000, 16'h00C0);
        bus(1, OFS_RTCS, 16'h0040, 16'h0000);
        bus(1, OFS_RCNT, 16'h0055, 16'h0000);
        bus(0, OFS_RCNT, 16'h0000, 16'h0055);
        check(IRQ, 1'b0);
        ACC_BUSY <= 1'b0;
        @(posedge REF_CLK);
        check(REFRESH_REQ, 1'b1);
        repeat (4) @(posedge REF_CLK);
        check(REFRESH_REQ, 1'b0);
        bus(1, OFS_RCNT, 16'h0000, 16'h0000);
        bus(1, OFS_RTCS, 16'h0008, 16'h0000);
        bus(1, OFS_MTC, 16'h000C, 16'h0000);
        repeat (2) @(posedge REF_CLK);
        check(SELF_REFRESH, 1'b1);
        n = 0;
        repeat (30) begin
            @(posedge REF_CLK);
            n += int'(REFRESH_REQ !== 1'b0);
        end
        check(n, 0);
        SLAVE_MODE <= 1'b1;
        bus(1, OFS_MTC, 16'h0008, 16'h0000);
        repeat (30) begin
            @(posedge REF_CLK);
            n += int'(REFRESH_REQ !== 1'b0);
        end
        check(n, 0);
        SLAVE_MODE <= 1'b0;
        $display("refresh done");
        access(2'h3, 2'h3, 1'b0, 32'h0000_0300, 2'h2, 1'b0);
        repeat (2) @(posedge REF_CLK);
        check(XFER_AUTO_PRE, 1'b1);
        bus(1, OFS_RCON, 16'h0002, 16'h0000);
        for (int c = 1; c < 8; c++) begin
            slow <= c[0];
            bus(1, OFS_RTCS, 16'(c << 3), 16'h0000);
            // early rises may straddle the select change; time the third one
            wait_req(n);
            hold_req(m);
            wait_req(n);
            hold_req(m);
            wait_req(n);
            check(m + n, 2 << DIV_SHIFT[c]);
        end
        $display("prescaler done");
        stop_test();
    end
endmodule
